/* lgtd_ctl.sv */
// Purpose: current mode, display test and one-shot transition detect control
// Assumes: AHB-Lite slave, word per register, byte address = 4 * index
// Notes:   zero wait states, response always OKAY
`timescale 1ns/1ps
`include "lgtd_defines.svh"
module lgtd_ctl
    import lgtd_pkg::*;
#(
    parameter int NPORT = 7,
    parameter int NSEG  = 28
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [NPORT-1:0]  monitored_ports,
    input  wire logic [NSEG-1:0]   seg_is_led,
    output logic                   alert_pin_o,
    output logic                   alert_pin_oe,
    output logic [NSEG*4-1:0]      seg_current,
    output logic [NSEG-1:0]        seg_force_on,
    output logic                   shutdown_n
);
    // elaboration checks: mask and segment register layout are fixed
    if (NPORT != 7) begin : g_bad_nport
        $error("NPORT must be 7");
    end
    if (NSEG != `LGTD_SEG_CUR_COUNT * 2) begin : g_bad_nseg
        $error("NSEG must be 28");
    end

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic        wr_ff, rd_ff, nxt_wr, nxt_rd;
    logic [7:0]  idx_ff, nxt_idx;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic        acc_valid;

    always_comb begin
        acc_valid = hsel && hready && htrans[1];
        nxt_wr    = acc_valid && hwrite;
        nxt_rd    = acc_valid && !hwrite;
        nxt_idx   = acc_valid ? haddr[9:2] : idx_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [7:0]  gcur_ff, nxt_gcur;
    logic [7:0]  cfg_ff, nxt_cfg;
    logic [6:0]  mask_ff, nxt_mask;
    logic        dtest_ff, nxt_dtest;
    logic [7:0]  pcfg_ff, nxt_pcfg;
    logic [7:0]  segreg_ff [`LGTD_SEG_CUR_COUNT];
    logic [7:0]  nxt_segreg [`LGTD_SEG_CUR_COUNT];
    logic        cfg_wr_en, mask_acc;

    always_comb begin
        nxt_gcur  = gcur_ff;
        nxt_cfg   = cfg_ff;
        nxt_mask  = mask_ff;
        nxt_dtest = dtest_ff;
        nxt_pcfg  = pcfg_ff;
        for (int i = 0; i < `LGTD_SEG_CUR_COUNT; i++) begin
            nxt_segreg[i] = segreg_ff[i];
        end
        if (wr_ff) begin
            if (idx_ff == `LGTD_GLOBAL_CUR_IDX) begin
                nxt_gcur = hwdata[7:0];
            end else if (idx_ff == `LGTD_CONFIG_IDX) begin
                nxt_cfg = hwdata[7:0];
            end else if (idx_ff == `LGTD_MASK_IDX) begin
                nxt_mask = hwdata[6:0];
            end else if (idx_ff == `LGTD_DISP_TEST_IDX) begin
                nxt_dtest = hwdata[0];
            end else if (idx_ff == `LGTD_PORT_CFG_IDX) begin
                nxt_pcfg = hwdata[7:0];
            end else if (idx_ff >= `LGTD_SEG_CUR_FIRST && idx_ff <= `LGTD_SEG_CUR_LAST) begin
                nxt_segreg[4'(idx_ff - `LGTD_SEG_CUR_FIRST)] = hwdata[7:0];
            end
        end
        // config write with enable set arms and snapshots
        cfg_wr_en = wr_ff && idx_ff == `LGTD_CONFIG_IDX && hwdata[`LGTD_CFG_DETEN_BIT];
        mask_acc  = (wr_ff || rd_ff) && idx_ff == `LGTD_MASK_IDX;
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronised ports and detector
    logic [NPORT-1:0] port_sync;
    logic [NPORT-1:0] snap_ff, nxt_snap;
    logic             flag_ff, nxt_flag;
    lgtd_det_state_t  st_ff, nxt_st;
    logic             cfg_wr_dis, change;

    lgtd_sync #(.WIDTH(NPORT)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     (monitored_ports),
        .dout    (port_sync)
    );

    always_comb begin
        cfg_wr_dis = wr_ff && idx_ff == `LGTD_CONFIG_IDX && !hwdata[`LGTD_CFG_DETEN_BIT];
        // level compare regardless of port direction
        change   = |((port_sync ^ snap_ff) & mask_ff);
        nxt_snap = cfg_wr_en ? port_sync : snap_ff;
        nxt_st   = st_ff;
        nxt_flag = flag_ff;
        case (st_ff)
            LGTD_IDLE: begin
                if (cfg_wr_en) begin
                    nxt_st   = LGTD_ARMED;
                    nxt_flag = 1'b0;
                end
            end
            LGTD_ARMED: begin
                if (cfg_wr_dis) begin
                    nxt_st = LGTD_IDLE;
                end else if (cfg_wr_en) begin
                    nxt_st   = LGTD_ARMED;
                    nxt_flag = 1'b0;
                end else if (change) begin
                    nxt_st   = LGTD_FIRED;
                    nxt_flag = 1'b1;
                end
            end
            LGTD_FIRED: begin
                nxt_flag = 1'b1;
                if (cfg_wr_en) begin
                    nxt_st   = LGTD_ARMED;
                    nxt_flag = 1'b0;
                end else if (mask_acc) begin
                    nxt_st   = LGTD_IDLE;
                    nxt_flag = 1'b0;
                end
            end
            default: begin
                nxt_st   = LGTD_IDLE;
                nxt_flag = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read data taken at the address phase edge so it stands in the data phase;
    // next values forward a write in flight, the clearing read still sees the flag
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        if (nxt_rd) begin
            if (nxt_idx == `LGTD_GLOBAL_CUR_IDX) begin
                nxt_hrdata = {24'h00_0000, nxt_gcur};
            end else if (nxt_idx == `LGTD_CONFIG_IDX) begin
                nxt_hrdata = {24'h00_0000, nxt_cfg[7:6], 5'h00, nxt_cfg[0]};
            end else if (nxt_idx == `LGTD_MASK_IDX) begin
                nxt_hrdata = {24'h00_0000, nxt_flag, nxt_mask};
            end else if (nxt_idx == `LGTD_DISP_TEST_IDX) begin
                nxt_hrdata = {31'h0000_0000, nxt_dtest};
            end else if (nxt_idx == `LGTD_PORT_CFG_IDX) begin
                nxt_hrdata = {24'h00_0000, nxt_pcfg};
            end else if (nxt_idx >= `LGTD_SEG_CUR_FIRST && nxt_idx <= `LGTD_SEG_CUR_LAST) begin
                nxt_hrdata = {24'h00_0000, nxt_segreg[4'(nxt_idx - `LGTD_SEG_CUR_FIRST)]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // led drive outputs
    logic [NSEG*4-1:0] nxt_cur;
    logic [NSEG*4-1:0] cur_ff;
    logic [NSEG-1:0]   nxt_force, force_ff;
    logic              nxt_alert, alert_ff, nxt_alert_oe, alert_oe_ff;

    genvar g;
    generate
        for (g = 0; g < NSEG; g++) begin : g_seg
            always_comb begin
                if (dtest_ff) begin
                    nxt_cur[g*4 +: 4] = `LGTD_HALF_CURRENT;
                end else if (cfg_ff[`LGTD_CFG_INDIV_BIT]) begin
                    nxt_cur[g*4 +: 4] = segreg_ff[g/2][(g%2)*4 +: 4];
                end else begin
                    nxt_cur[g*4 +: 4] = gcur_ff[3:0];
                end
                nxt_force[g] = dtest_ff && seg_is_led[g];
            end
        end
    endgenerate

    always_comb begin
        nxt_alert_oe = !pcfg_ff[7] && pcfg_ff[6];
        nxt_alert    = nxt_alert_oe && nxt_flag;
    end

    ////////////////////////////////////////////////////////////////////////
    // all registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff       <= 1'b0;
            rd_ff       <= 1'b0;
            idx_ff      <= 8'h00;
            hrdata_ff   <= 32'h0000_0000;
            gcur_ff     <= 8'h00;
            cfg_ff      <= 8'h00;
            mask_ff     <= 7'h00;
            dtest_ff    <= 1'b0;
            pcfg_ff     <= `LGTD_PORT_CFG_RESET;
            for (int i = 0; i < `LGTD_SEG_CUR_COUNT; i++) begin
                segreg_ff[i] <= 8'h00;
            end
            snap_ff     <= '0;
            flag_ff     <= 1'b0;
            st_ff       <= LGTD_IDLE;
            cur_ff      <= '0;
            force_ff    <= '0;
            alert_ff    <= 1'b0;
            alert_oe_ff <= 1'b0;
        end else begin
            wr_ff       <= nxt_wr;
            rd_ff       <= nxt_rd;
            idx_ff      <= nxt_idx;
            hrdata_ff   <= nxt_hrdata;
            gcur_ff     <= nxt_gcur;
            cfg_ff      <= nxt_cfg;
            mask_ff     <= nxt_mask;
            dtest_ff    <= nxt_dtest;
            pcfg_ff     <= nxt_pcfg;
            for (int i = 0; i < `LGTD_SEG_CUR_COUNT; i++) begin
                segreg_ff[i] <= nxt_segreg[i];
            end
            snap_ff     <= nxt_snap;
            flag_ff     <= nxt_flag;
            st_ff       <= nxt_st;
            cur_ff      <= nxt_cur;
            force_ff    <= nxt_force;
            alert_ff    <= nxt_alert;
            alert_oe_ff <= nxt_alert_oe;
        end
    end

    // outputs straight from flops, hreadyout and hresp tied off; hrdata valid in the data phase
    assign hrdata       = hrdata_ff;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign alert_pin_o  = alert_ff;
    assign alert_pin_oe = alert_oe_ff;
    assign seg_current  = cur_ff;
    assign seg_force_on = force_ff;
    assign shutdown_n   = cfg_ff[`LGTD_CFG_SHDN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_snap;
        @(posedge hclk) disable iff (!hresetn) cfg_wr_en |=> snap_ff == $past(port_sync);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot not taken");

    property p_arm;
        @(posedge hclk) disable iff (!hresetn) cfg_wr_en |=> !flag_ff && st_ff == LGTD_ARMED;
    endproperty
    a_arm: assert property (p_arm) else $error("enable did not arm");

    property p_set;
        @(posedge hclk) disable iff (!hresetn)
            st_ff == LGTD_ARMED && change && !wr_ff |=> flag_ff;
    endproperty
    a_set: assert property (p_set) else $error("change not flagged");

    property p_hold;
        @(posedge hclk) disable iff (!hresetn)
            flag_ff && !mask_acc && !cfg_wr_en |=> flag_ff;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");

    // the clearing read returns the flag set in its data phase, then it drops
    property p_clr;
        @(posedge hclk) disable iff (!hresetn)
            flag_ff && rd_ff && mask_acc |-> hrdata_ff[7] ##1 !flag_ff;
    endproperty
    a_clr: assert property (p_clr) else $error("clear read wrong");

    property p_oneshot;
        @(posedge hclk) disable iff (!hresetn)
            st_ff == LGTD_FIRED && mask_acc |=> st_ff == LGTD_IDLE ##1 !flag_ff;
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("detector not one-shot");

    // a disabling config write idles the detector unless it has fired; a fired one ignores it and keeps its flag until a mask access or enabling write
    property p_dis;
        @(posedge hclk) disable iff (!hresetn)
            cfg_wr_dis && st_ff != LGTD_FIRED |=> st_ff == LGTD_IDLE;
    endproperty
    a_dis: assert property (p_dis) else $error("disable ignored");

    property p_half;
        @(posedge hclk) disable iff (!hresetn) dtest_ff |=> cur_ff[3:0] == `LGTD_HALF_CURRENT;
    endproperty
    a_half: assert property (p_half) else $error("test current wrong");

    property p_alert;
        @(posedge hclk) disable iff (!hresetn) alert_oe_ff |-> alert_ff == flag_ff;
    endproperty
    a_alert: assert property (p_alert) else $error("alert not following flag");
endmodule : lgtd_ctl

/* lgtd_defines.svh */
// Purpose: constants for the led/gpio transition detect control block
// Assumes: word register indices on a 32-bit AHB-Lite register bus
// Notes:   definitions only
`ifndef LGTD_DEFINES_SVH
`define LGTD_DEFINES_SVH
`define LGTD_GLOBAL_CUR_IDX   8'h02
`define LGTD_CONFIG_IDX       8'h04
`define LGTD_MASK_IDX         8'h06
`define LGTD_DISP_TEST_IDX    8'h07
`define LGTD_PORT_CFG_IDX     8'h0F
`define LGTD_SEG_CUR_FIRST    8'h12
`define LGTD_SEG_CUR_LAST     8'h1F
`define LGTD_CFG_SHDN_BIT     0
`define LGTD_CFG_INDIV_BIT    6
`define LGTD_CFG_DETEN_BIT    7
`define LGTD_MASK_FLAG_BIT    7
`define LGTD_HALF_CURRENT     4'h7
`define LGTD_PORT_CFG_RESET   8'hAA
`define LGTD_SEG_CUR_COUNT    14
`endif

/* lgtd_pkg.sv */
// Purpose: types for the led/gpio transition detect control block
// Assumes: constants live in lgtd_defines.svh
// Notes:   one-hot detector states
package lgtd_pkg;
    typedef enum logic [2:0] {
        LGTD_IDLE  = 3'b001,
        LGTD_ARMED = 3'b010,
        LGTD_FIRED = 3'b100
    } lgtd_det_state_t;
endpackage : lgtd_pkg

/* lgtd_sync.sv */
// Purpose: two-flop synchroniser for the monitored port levels
// Assumes: single clock hclk, async active-low reset
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
module lgtd_sync #(
    parameter int WIDTH = 7
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] nxt_stage1;
    logic [WIDTH-1:0] nxt_stage2;

    // next values
    always_comb begin
        nxt_stage1 = din;
        nxt_stage2 = stage1_ff;
    end

    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
        end else begin
            stage1_ff <= nxt_stage1;
            stage2_ff <= nxt_stage2;
        end
    end

    assign dout = stage2_ff;
endmodule : lgtd_sync

/* lgtd_host_model.sv */
// Purpose: host side model that drives the AHB-Lite register bus
// Assumes: one slave whose hreadyout is the bus hready, single word transfers
// Notes:   the bench calls the tasks by hierarchical name
`timescale 1ns/1ps
`include "lgtd_defines.svh"
module lgtd_host_model (
    input  wire logic        hclk,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    // bus idle at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte address of a register index
    function automatic logic [31:0] addr_of(input logic [7:0] idx);
        return {22'h0, idx, 2'b00};
    endfunction : addr_of

    // one transfer: address phase, then data phase, each held until hready
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= addr_of(idx);
        htrans <= 2'h2;
        hwrite <= w;
        // only the bench watchdog ends a wait
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
        q = hrdata;
        // released lines show no stale value
        haddr  <= ~addr_of(idx);
        hwdata <= ~d;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, idx, d, q);
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        xfer(1'b0, idx, 32'h0, q);
    endtask : rd

    // mask and alert pin set up before detection is enabled
    task automatic arm(input logic [31:0] mask, input logic [31:0] cfg);
        wr(`LGTD_MASK_IDX, mask);
        wr(`LGTD_PORT_CFG_IDX, 32'h6A);
        wr(`LGTD_CONFIG_IDX, cfg);
    endtask : arm
endmodule : lgtd_host_model

/* led_gpio_transition_detect_ctl_tb.sv */
// Purpose: self-checking bench for current select, display test and change detect
// Assumes: zero wait register bus, two-flop port synchroniser
// Notes:   global code rows run in one loop, detector cases by hand
`timescale 1ns/1ps
`include "lgtd_defines.svh"
module led_gpio_transition_detect_ctl_tb;
    logic         hclk;
    logic         hresetn;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic [31:0]  hrdata;
    logic         hreadyout;
    logic         hresp;
    logic [6:0]   monitored_ports;
    logic [27:0]  seg_is_led;
    logic         alert_pin_o;
    logic         alert_pin_oe;
    logic [111:0] seg_current;
    logic [27:0]  seg_force_on;
    logic         shutdown_n;
    logic [11:0]  rows [4];
    int           fail_count;
    int           n_checks;

    lgtd_ctl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .monitored_ports(monitored_ports), .seg_is_led(seg_is_led),
        .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe),
        .seg_current(seg_current), .seg_force_on(seg_force_on), .shutdown_n(shutdown_n));

    lgtd_host_model host (.hclk(hclk), .hrdata(hrdata), .hreadyout(hreadyout),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 50 MHz
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        host.rd(idx, q);
        chk(name, exp, q);
    endtask : rdchk

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    task automatic setp(input logic [6:0] v);
        @(posedge hclk);
        monitored_ports <= v;
    endtask : setp

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    // watchdog against a hung handshake
    initial begin
        #(3000 * 20);
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        fail_count      = 0;
        n_checks        = 0;
        hresetn         = 1'b0;
        monitored_ports = 7'h00;
        seg_is_led      = 28'hFF0F0F1;
        rows            = '{12'h000, 12'h0FF, 12'hF55, 12'hA99}; // {write data, nibble}
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        chk("oe_rst", 32'h0, {31'h0, alert_pin_oe});
        chk("rdy_resp", 32'h2, {30'h0, hreadyout, hresp});
        chk("shdn_rst", 32'h0, {31'h0, shutdown_n});
        $display("test reset done");
        // global code rows
        host.wr(`LGTD_CONFIG_IDX, 32'h01);
        for (int i = 0; i < 4; i++) begin
            host.wr(`LGTD_GLOBAL_CUR_IDX, {24'h0, rows[i][11:4]});
            tick(2);
            chk("glob_cur", {8{rows[i][3:0]}}, seg_current[31:0]);
            chk("glob_hi", {8{rows[i][3:0]}}, seg_current[111:80]);
        end
        chk("shdn_on", 32'h1, {31'h0, shutdown_n});
        $display("test global current done");
        // individual nibbles, first and last register
        host.wr(`LGTD_CONFIG_IDX, 32'h41);
        host.wr(`LGTD_SEG_CUR_FIRST, 32'h53);
        host.wr(`LGTD_SEG_CUR_LAST, 32'hE2);
        tick(2);
        chk("seg_first", 32'h3, {28'h0, seg_current[3:0]});
        chk("seg_last", 32'hE2, {24'h0, seg_current[111:104]});
        host.wr(`LGTD_CONFIG_IDX, 32'h01);
        tick(2);
        chk("back_glob", 32'h9, {28'h0, seg_current[3:0]});
        $display("test individual current done");
        // display test on and off
        host.wr(`LGTD_DISP_TEST_IDX, 32'h01);
        tick(2);
        chk("force_on", {4'h0, seg_is_led}, {4'h0, seg_force_on});
        chk("half_cur", {28'h0, `LGTD_HALF_CURRENT}, {28'h0, seg_current[3:0]});
        host.wr(`LGTD_DISP_TEST_IDX, 32'h00);
        tick(2);
        chk("force_off", 32'h0, {4'h0, seg_force_on});
        chk("kept_cur", 32'h9, {28'h0, seg_current[3:0]});
        $display("test display test done");
        // arm, pulse, sticky, clear by read, one-shot
        host.arm(32'h7F, 32'hBF);
        tick(2);
        chk("alert_oe", 32'h1, {31'h0, alert_pin_oe});
        rdchk("cfg_rb", `LGTD_CONFIG_IDX, 32'h81);
        rdchk("mask_armed", `LGTD_MASK_IDX, 32'h7F);
        chk("alert_armed", 32'h0, {31'h0, alert_pin_o});
        setp(7'h01);
        setp(7'h00);
        tick(5);
        chk("alert_pulse", 32'h1, {31'h0, alert_pin_o});
        setp(7'h10);
        tick(5);
        setp(7'h00);
        tick(5);
        chk("alert_sticky", 32'h1, {31'h0, alert_pin_o});
        rdchk("mask_set", `LGTD_MASK_IDX, 32'hFF);
        rdchk("mask_clr", `LGTD_MASK_IDX, 32'h7F);
        tick(2);
        chk("alert_clr", 32'h0, {31'h0, alert_pin_o});
        setp(7'h02);
        tick(5);
        chk("one_shot", 32'h0, {31'h0, alert_pin_o});
        rdchk("mask_idle", `LGTD_MASK_IDX, 32'h7F);
        $display("test detect one-shot done");
        // rearm with a new snapshot and a masked port
        host.arm(32'h7E, 32'h81);
        tick(4);
        setp(7'h03);
        tick(5);
        chk("masked", 32'h0, {31'h0, alert_pin_o});
        setp(7'h43);
        tick(5);
        chk("unmasked", 32'h1, {31'h0, alert_pin_o});
        host.wr(`LGTD_MASK_IDX, 32'h7E);
        tick(2);
        chk("clr_write", 32'h0, {31'h0, alert_pin_o});
        // enable then disable by a config write
        host.wr(`LGTD_CONFIG_IDX, 32'h81);
        tick(4);
        host.wr(`LGTD_CONFIG_IDX, 32'h01);
        tick(4);
        setp(7'h00);
        tick(5);
        chk("disabled", 32'h0, {31'h0, alert_pin_o});
        rdchk("mask_off", `LGTD_MASK_IDX, 32'h7E);
        rdchk("unmapped", 8'h30, 32'h0);
        // enable write while fired rearms and clears the flag
        host.wr(`LGTD_CONFIG_IDX, 32'h81);
        tick(4);
        setp(7'h41);
        tick(5);
        chk("fired", 32'h1, {31'h0, alert_pin_o});
        host.wr(`LGTD_CONFIG_IDX, 32'h81);
        tick(2);
        chk("rearm_fired", 32'h0, {31'h0, alert_pin_o});
        $display("test rearm and disable done");
        // second reset in mid-run
        @(posedge hclk);
        hresetn <= 1'b0;
        tick(2);
        chk("oe_rst2", 32'h0, {31'h0, alert_pin_oe});
        chk("cur_rst2", 32'h0, seg_current[31:0]);
        chk("shdn_rst2", 32'h0, {31'h0, shutdown_n});
        hresetn <= 1'b1;
        tick(2);
        rdchk("cfg_rst2", `LGTD_CONFIG_IDX, 32'h0);
        rdchk("mask_rst2", `LGTD_MASK_IDX, 32'h0);
        chk("alert_rst2", 32'h0, {31'h0, alert_pin_o});
        $display("test second reset done");
        complete_run();
    end
endmodule : led_gpio_transition_detect_ctl_tb
